// ===== rtcis_port.sv
/*
  Two-wire slave port of the real-time clock: bus engine on the link
  clock, register array and supply monitoring on the system clock.
  Assumes the link clock oversamples SCL by at least eight, that SDA is
  resolved by the bench from sda_oe (pull-down when high), and that the
  master follows the protocol obligations listed below.
*/
// Function
// RL1: one bit per SCL pulse; SDA moves only while SCL is low
// RL2: SDA falling while SCL high is a start condition
// RL3: SDA rising while SCL high is a stop condition
// RL4: both lines high outside transfers; bus is then idle
// RL5: master starts a transfer only on an idle bus
// RL6: no repeated start; each transfer ends with stop first
// RL7: device is slave only; never drives SCL nor makes start/stop
// RL8: any byte count; eight bits MSB first, then ack clock
// RL9: addressed receiver acknowledges every byte, address included
// RL10: master acknowledges each read byte except the last wanted
// RL11: acknowledger holds SDA low through the ack clock high phase
// RL12: master ends a read by not acknowledging the last byte
// RL13: after a not-acknowledge the device releases SDA and stops sending
// RL14: respond only when the seven address bits match the fixed address
// RL15: address LSB one means read, zero means write
// RL16: master closes every write transfer with stop
// RL17: on battery the port is inactive; master finishes beforehand
// RL18: power-fail output warns early; master then closes the transfer
// RL19: transfer cut by the supply switch is flagged as a hazard
// RL20: after an abort the master sends stop then start to resync
// RL21: pointer advances after each byte and wraps after the last register
// RL22: static select input chooses two-wire mode when high
// RL23: first written byte loads the pointer; reads start at the pointer
`timescale 1ns/1ps
module rtcis_port (
  // system clock domain
  input  logic                       clk_sys,
  input  logic                       sys_rst,
  input  logic                       ce,
  // link clock
  input  logic                       clk_link,
  // two-wire pins
  input  logic                       scl_in,
  input  logic                       sda_in,
  output logic                       sda_out,
  output logic                       sda_oe,
  // supply and mode
  input  logic                       port_select_in,
  input  logic                       on_battery,
  input  logic                       vdd_low_in,
  output logic                       power_fail_out,
  input  logic                       hazard_clear,
  output logic                       corrupt_hazard,
  // clock core access to the registers
  input  logic                       core_we,
  input  logic [rtcis_pkg::PTR_W-1:0] core_addr,
  input  logic [7:0]                 core_wdata,
  output logic [7:0]                 core_rdata
);
  import rtcis_pkg::*;

  // link domain state
  typedef struct packed {
    rtcis_state_type st;
    rtcis_phase_type ph;
    logic [3:0]      cnt;
    logic [7:0]      sh;
    logic [7:0]      txb;
    logic [7:0]      nxt;
    logic [4:0]      ptr;
    logic            rw;
    logic            mack;
    logic            oe;
    logic            sdo;
    logic            scl_q;
    logic            sda_q;
    logic            busy;
    logic            req_tog;
    logic            req_we;
    logic [4:0]      req_addr;
    logic [7:0]      req_wdata;
    logic            ack_q;
  } rtcis_link_type;

  // system domain state
  typedef struct packed {
    logic pf;
    logic hz;
  } rtcis_sys_type;

  rtcis_link_type r_l;
  rtcis_link_type next_r_l;
  rtcis_sys_type  r_s;
  rtcis_sys_type  next_r_s;

  logic       rst_l;
  logic       ce_l;
  logic       scl;
  logic       sda;
  logic       sel_l;
  logic       bat_l;
  logic       ack_s;
  logic       bat_s;
  logic       low_s;
  logic       busy_s;
  logic       req_s;
  logic       ack_tog;
  logic [7:0] rsp_data;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;

  // reset and clock enable into the link domain; no reset of their own
  rtcis_sync #(.W(2)) u_lctl (
    .clk (clk_link),
    .rst (1'b0),
    .en  (1'b1),
    .d   ({sys_rst, ce}),
    .q   ({rst_l, ce_l})
  );

  // pins, mode strap, battery level and answer toggle into the link domain
  rtcis_sync #(.W(5)) u_lin (
    .clk (clk_link),
    .rst (rst_l),
    .en  (ce_l),
    .d   ({scl_in, sda_in, port_select_in, on_battery, ack_tog}),
    .q   ({scl, sda, sel_l, bat_l, ack_s})
  );

  // supply levels, link busy and request toggle into the system domain
  rtcis_sync #(.W(4)) u_sin (
    .clk (clk_sys),
    .rst (sys_rst),
    .en  (ce),
    .d   ({on_battery, vdd_low_in, r_l.busy, r_l.req_tog}),
    .q   ({bat_s, low_s, busy_s, req_s})
  );

  // register array; request words are held, only the toggle is synchronised
  rtcis_regs u_regs (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .ce         (ce),
    .req_tog    (req_s),
    .req_we     (r_l.req_we),
    .req_addr   (r_l.req_addr),
    .req_wdata  (r_l.req_wdata),
    .ack_tog    (ack_tog),
    .rsp_data   (rsp_data),
    .core_we    (core_we),
    .core_addr  (core_addr),
    .core_wdata (core_wdata),
    .core_rdata (core_rdata)
  );

  // post a register request; the previous one is long done by byte spacing
  function automatic rtcis_link_type issue_req(
    input rtcis_link_type s,
    input logic           we,
    input logic [4:0]     a,
    input logic [7:0]     d
  );
    rtcis_link_type t;
    t           = s;
    t.req_tog   = ~s.req_tog;
    t.req_we    = we;
    t.req_addr  = a;
    t.req_wdata = d;
    return t;
  endfunction

  // bus events from filtered levels; SDA moving with SCL high is control
  always_comb
  begin
    scl_rise   = scl & ~r_l.scl_q;
    scl_fall   = ~scl & r_l.scl_q;
    start_cond = scl & r_l.scl_q & ~sda & r_l.sda_q;  // [RL1] [RL2]
    stop_cond  = scl & r_l.scl_q & sda & ~r_l.sda_q;  // [RL1] [RL3]
  end

  // link engine: slave only, SCL is never driven [RL7]
  always_comb
  begin
    next_r_l = r_l;
    if (ce_l)
    begin
      next_r_l.scl_q = scl;
      next_r_l.sda_q = sda;
      // read answers land in the prefetch byte
      if (ack_s != r_l.ack_q)
      begin
        next_r_l.ack_q = ack_s;
        if (!r_l.req_we)
          next_r_l.nxt = rsp_data;
      end
      if (bat_l || !sel_l)
      begin
        // battery or other bus mode: port silent, abort needs resync
        next_r_l.oe   = 1'b0;                          // [RL17] [RL22]
        next_r_l.busy = 1'b0;
        next_r_l.st   = (r_l.st == ST_IDLE) ? ST_IDLE : ST_RESYNC;  // [RL20]
      end
      else if (stop_cond)
      begin
        next_r_l.st   = ST_IDLE;                       // [RL3] [RL4] [RL16]
        next_r_l.oe   = 1'b0;
        next_r_l.busy = 1'b0;
      end
      else if (start_cond && (r_l.st != ST_RESYNC))
      begin
        // a start mid-transfer simply reopens the address phase
        next_r_l.st   = ST_RX;                         // [RL2] [RL5] [RL6]
        next_r_l.ph   = PH_ADDR;
        next_r_l.cnt  = CNT_ZERO;
        next_r_l.oe   = 1'b0;
        next_r_l.busy = 1'b1;
      end
      else
      begin
        case (r_l.st)
          ST_RX:
          begin
            if (scl_rise && (r_l.cnt != BYTE_BITS))
            begin
              next_r_l.sh  = {r_l.sh[6:0], sda};       // [RL1] [RL8]
              next_r_l.cnt = 4'(r_l.cnt + CNT_STEP);
            end
            else if (scl_fall && (r_l.cnt == BYTE_BITS))
            begin
              case (r_l.ph)
                PH_ADDR:
                begin
                  if (r_l.sh[7:1] == SLAVE_ADDR)       // [RL14]
                  begin
                    next_r_l.rw = r_l.sh[0];           // [RL15]
                    next_r_l.oe = 1'b1;                // [RL9]
                    next_r_l.st = ST_RX_ACK;
                    if (r_l.sh[0])
                      next_r_l = issue_req(next_r_l, 1'b0, r_l.ptr, REG_RST);  // [RL23]
                  end
                  else
                  begin
                    next_r_l.st   = ST_SKIP;           // [RL14]
                    next_r_l.busy = 1'b0;
                  end
                end
                PH_PTR:
                begin
                  // an out-of-window pointer falls back to the first register
                  next_r_l.ptr = (r_l.sh > {3'b000, PTR_LAST}) ? PTR_RST
                                                              : r_l.sh[4:0];  // [RL23]
                  next_r_l.oe  = 1'b1;                 // [RL9]
                  next_r_l.st  = ST_RX_ACK;
                end
                default:
                begin
                  next_r_l     = issue_req(next_r_l, 1'b1, r_l.ptr, r_l.sh);
                  next_r_l.ptr = rtcis_ptr_next(r_l.ptr);  // [RL21]
                  next_r_l.oe  = 1'b1;                 // [RL9]
                  next_r_l.st  = ST_RX_ACK;
                end
              endcase
            end
          end
          ST_RX_ACK:
          begin
            // low held from one falling edge to the next covers the high phase
            if (scl_fall)
            begin
              if (r_l.rw)
              begin
                next_r_l.txb = {r_l.nxt[6:0], 1'b0};
                next_r_l.oe  = ~r_l.nxt[7];            // [RL8] [RL11]
                next_r_l.cnt = CNT_FIRST;
                next_r_l.st  = ST_TX;
              end
              else
              begin
                next_r_l.oe  = 1'b0;                   // [RL11]
                next_r_l.cnt = CNT_ZERO;
                next_r_l.st  = ST_RX;
                next_r_l.ph  = (r_l.ph == PH_ADDR) ? PH_PTR : PH_DATA;  // [RL23]
              end
            end
          end
          ST_TX:
          begin
            if (scl_fall)
            begin
              if (r_l.cnt == BYTE_BITS)
              begin
                // release for the master's ack and fetch the following byte
                next_r_l.oe  = 1'b0;
                next_r_l.ptr = rtcis_ptr_next(r_l.ptr);  // [RL21]
                next_r_l     = issue_req(next_r_l, 1'b0,
                                         rtcis_ptr_next(r_l.ptr), REG_RST);
                next_r_l.st  = ST_TX_ACK;
              end
              else
              begin
                next_r_l.oe  = ~r_l.txb[7];            // [RL1] [RL8]
                next_r_l.txb = {r_l.txb[6:0], 1'b0};
                next_r_l.cnt = 4'(r_l.cnt + CNT_STEP);
              end
            end
          end
          ST_TX_ACK:
          begin
            if (scl_rise)
              next_r_l.mack = ~sda;                    // [RL10] [RL11]
            else if (scl_fall)
            begin
              if (r_l.mack)
              begin
                next_r_l.txb = {r_l.nxt[6:0], 1'b0};
                next_r_l.oe  = ~r_l.nxt[7];            // [RL10]
                next_r_l.cnt = CNT_FIRST;
                next_r_l.st  = ST_TX;
              end
              else
              begin
                next_r_l.oe = 1'b0;                    // [RL12] [RL13]
                next_r_l.st = ST_SKIP;
              end
            end
          end
          default:
          begin
            // idle and skip wait for a start or a stop; resync ignores starts and waits for a stop
            next_r_l.oe = 1'b0;                        // [RL4]
          end
        endcase
      end
    end
    if (rst_l)
      next_r_l = '0;
  end

  always_ff @(posedge clk_link)
  begin
    r_l <= next_r_l;
  end

  // supply monitoring; a hazard raised in a clearing cycle is kept
  always_comb
  begin
    next_r_s = r_s;
    if (ce)
    begin
      next_r_s.pf = low_s;                             // [RL18]
      next_r_s.hz = (bat_s & busy_s) | (r_s.hz & ~hazard_clear);  // [RL19]
    end
    if (sys_rst)
      next_r_s = '0;
  end

  always_ff @(posedge clk_sys)
  begin
    r_s <= next_r_s;
  end

  // pin drive is open drain: sda_out stays low, sda_oe pulls
  assign sda_out        = r_l.sdo;
  assign sda_oe         = r_l.oe;
  assign power_fail_out = r_s.pf;
  assign corrupt_hazard = r_s.hz;
endmodule

// ===== rtcis_pkg.sv
/*
  Shared constants and types for the two-wire slave port of the clock chip.
  Assumes nothing beyond a SystemVerilog compiler; holds no logic but the pointer advance function.
*/
package rtcis_pkg;
  // register window reached through the pointer
  localparam int         PTR_W      = 5;
  localparam int         NUM_REGS   = 30;
  localparam logic [4:0] PTR_LAST   = 5'h1D;
  localparam logic [4:0] PTR_RST    = 5'h00;
  localparam logic [7:0] REG_RST    = 8'h00;
  // fixed slave address, binary 1010001
  localparam logic [6:0] SLAVE_ADDR = 7'h51;
  // bit counting within a byte
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [3:0] CNT_ZERO   = 4'h0;
  localparam logic [3:0] CNT_FIRST  = 4'h1;
  localparam logic [3:0] CNT_STEP   = 4'h1;

  // link state machine
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RX     = 3'b001,
    ST_RX_ACK = 3'b010,
    ST_TX     = 3'b011,
    ST_TX_ACK = 3'b100,
    ST_SKIP   = 3'b101,
    ST_RESYNC = 3'b110
  } rtcis_state_type;

  // meaning of the byte being received
  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_PTR  = 2'b01,
    PH_DATA = 2'b10
  } rtcis_phase_type;

  // pointer advance with wrap after the last register
  function automatic logic [4:0] rtcis_ptr_next(input logic [4:0] p);
    return (p >= PTR_LAST) ? PTR_RST : 5'(p + 5'h01);
  endfunction
endpackage

// ===== rtcis_sync.sv
/*
  Three-stage level synchroniser with agreement filter.
  Assumes each bit of d is an independent level; words must not pass here.
*/
`timescale 1ns/1ps
module rtcis_sync #(
  parameter int W = 1
) (
  // clocking
  input  logic         clk,
  input  logic         rst,
  input  logic         en,
  // levels
  input  logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] q;
  } rtcis_sync_type;

  rtcis_sync_type r;
  rtcis_sync_type next_r;

  // ff1 feeds only ff2; output moves once stages two and three agree
  always_comb
  begin
    next_r = r;
    if (en)
    begin
      next_r.ff1 = d;
      next_r.ff2 = r.ff1;
      next_r.ff3 = r.ff2;
      for (int i = 0; i < W; i++)
      begin
        if (r.ff2[i] == r.ff3[i])
          next_r.q[i] = r.ff3[i];
      end
    end
    if (rst)
      next_r = '0;
  end

  always_ff @(posedge clk)
  begin
    r <= next_r;
  end

  assign q = r.q;
endmodule

// ===== rtcis_regs.sv
/*
  Register array behind the pointer, on the system clock.
  Assumes the request fields are held stable by the link side from before
  the request toggle changes until after the acknowledge toggle returns.
*/
`timescale 1ns/1ps
module rtcis_regs (
  // clocking
  input  logic                       clk_sys,
  input  logic                       sys_rst,
  input  logic                       ce,
  // link requests (toggle already synchronised)
  input  logic                       req_tog,
  input  logic                       req_we,
  input  logic [rtcis_pkg::PTR_W-1:0] req_addr,
  input  logic [7:0]                 req_wdata,
  output logic                       ack_tog,
  output logic [7:0]                 rsp_data,
  // clock core access
  input  logic                       core_we,
  input  logic [rtcis_pkg::PTR_W-1:0] core_addr,
  input  logic [7:0]                 core_wdata,
  output logic [7:0]                 core_rdata
);
  import rtcis_pkg::*;

  typedef struct packed {
    logic [NUM_REGS-1:0][7:0] regs;
    logic                     seen;
    logic                     ack;
    logic [7:0]               rsp;
    logic [7:0]               crd;
  } rtcis_regs_type;

  rtcis_regs_type r;
  rtcis_regs_type next_r;

  // core access first, link write last: a link write wins a same-cycle clash
  always_comb
  begin
    next_r = r;
    if (ce)
    begin
      next_r.crd = (core_addr <= PTR_LAST) ? r.regs[core_addr] : REG_RST;
      if (core_we && (core_addr <= PTR_LAST))
        next_r.regs[core_addr] = core_wdata;
      if (req_tog != r.seen)
      begin
        next_r.seen = req_tog;
        next_r.ack  = ~r.ack;
        if (req_we)
          next_r.regs[req_addr] = req_wdata;
        else
          next_r.rsp = r.regs[req_addr];
      end
    end
    if (sys_rst)
      next_r = '0;
  end

  always_ff @(posedge clk_sys)
  begin
    r <= next_r;
  end

  assign ack_tog    = r.ack;
  assign rsp_data   = r.rsp;
  assign core_rdata = r.crd;
endmodule

// ===== rtcis_port_assertions.sv
/*
  Protocol checker for the two-wire slave port, bound to rtcis_port.
  Assumes a pull-up bus resolved outside and a master at <= 400 kHz.
*/
`timescale 1ns/1ps
module rtcis_port_assertions (
  // clocks and reset
  input logic clk_sys,
  input logic sys_rst,
  input logic clk_link,
  // bus pins
  input logic scl_in,
  input logic sda_out,
  input logic sda_oe,
  // supply and mode
  input logic port_select_in,
  input logic on_battery,
  input logic vdd_low_in,
  input logic power_fail_out,
  input logic hazard_clear,
  input logic corrupt_hazard
);
  // link side: sda only moves while scl is low
  AST_OE_SCL_LOW: assert property (@(posedge clk_link) disable iff (sys_rst)
    $changed(sda_oe) |-> !scl_in) else $error("sda_oe moved while scl high");
  AST_ACK_HOLD: assert property (@(posedge clk_link) disable iff (sys_rst)
    sda_oe && scl_in && port_select_in && !on_battery |=> sda_oe)
    else $error("sda released during scl high");
  AST_SDA_ZERO: assert property (@(posedge clk_link) disable iff (sys_rst)
    sda_oe |-> sda_out == 1'b0) else $error("open drain value not low");
  AST_BATT_SILENT: assert property (@(posedge clk_link) disable iff (sys_rst)
    on_battery [*6] |-> !sda_oe) else $error("port drives sda on battery");
  AST_SEL_SILENT: assert property (@(posedge clk_link) disable iff (sys_rst)
    !port_select_in [*6] |-> !sda_oe) else $error("port drives sda when deselected");
  // system side: supply warning and hazard flag
  AST_PF_HIGH: assert property (@(posedge clk_sys) disable iff (sys_rst)
    vdd_low_in [*7] |-> power_fail_out) else $error("power fail not raised");
  AST_PF_LOW: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !vdd_low_in [*7] |-> !power_fail_out) else $error("power fail not dropped");
  AST_HAZ_STICKY: assert property (@(posedge clk_sys) disable iff (sys_rst)
    corrupt_hazard && !hazard_clear |=> corrupt_hazard) else $error("hazard lost");
  AST_HAZ_QUIET: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!on_battery) [*8] |=> !$rose(corrupt_hazard)) else $error("hazard without battery");
  AST_HAZ_CLEARED: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!on_battery) [*8] ##1 hazard_clear |=> !corrupt_hazard)
    else $error("hazard not cleared");
endmodule

bind rtcis_port rtcis_port_assertions u_chk (
  .clk_sys, .sys_rst, .clk_link, .scl_in, .sda_out, .sda_oe, .port_select_in,
  .on_battery, .vdd_low_in, .power_fail_out, .hazard_clear, .corrupt_hazard
);

// ===== rtcis_master.sv
/*
  Behavioural two-wire bus master driving the slave port.
  Assumes a pull-up wire resolved by the bench; bit time is 24 link clocks.
*/
`timescale 1ns/1ps
module rtcis_master (
  // clock and resolved data wire
  input  logic       clk,
  input  logic       sda_in,
  // driven lines, high means released
  output logic       scl,
  output logic       sda_drv,
  // byte result strobe for the bench
  output logic       obs_vld,
  output logic [7:0] obs_data
);
  // idle bus rests high
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
    obs_vld = 1'b0;
    obs_data = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // data set mid low phase, sampled late in high phase
  task automatic bit_out(input logic b, output logic s);
    tick(6);
    sda_drv <= b;
    tick(6);
    scl <= 1'b1;
    tick(11);
    s = sda_in;
    tick(1);
    scl <= 1'b0;
  endtask
  // also used mid-transfer, which forms the forbidden repeated start
  task automatic start();
    sda_drv <= 1'b1;
    tick(6);
    scl <= 1'b1;
    tick(12);
    sda_drv <= 1'b0;
    tick(12);
    scl <= 1'b0;
  endtask
  task automatic stop();
    tick(6);
    sda_drv <= 1'b0;
    tick(6);
    scl <= 1'b1;
    tick(12);
    sda_drv <= 1'b1;
    tick(12);
  endtask
  // eight bits msb first, then the ack clock; reads ack unless last
  task automatic xfer(input logic [7:0] tx, input logic rd, input logic last);
    logic [7:0] r;
    logic       a;
    for (int i = 7; i >= 0; i--) bit_out(tx[i], r[i]);
    bit_out(rd ? last : 1'b1, a);
    obs_data <= rd ? r : {7'h00, ~a};
    obs_vld <= 1'b1;
    tick(1);
    obs_vld <= 1'b0;
  endtask
endmodule

// ===== tb_top.sv
/*
  Self-checking bench for rtcis_port with a behavioural bus master.
  Assumes the port, its package and the master model are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  import rtcis_pkg::*;
  logic clk_sys = 1'b0, clk_link = 1'b0, sys_rst, ce, port_select_in, on_battery;
  logic vdd_low_in, hazard_clear, core_we, power_fail_out, corrupt_hazard;
  logic sda_out, sda_oe, scl, sda_drv, obs_vld;
  logic [4:0] core_addr;
  logic [7:0] core_wdata, core_rdata, obs_data, cw;
  logic [7:0] d [3];
  logic [7:0] q [$];
  int mismatches = 0, total_checks = 0, cycles = 0;
  int seed = 32'h9d85_4340;
  wire sda = sda_drv & ~sda_oe; // pull-up wire
  // unrelated clock phases
  always #10 clk_sys = ~clk_sys;
  always #62.5 clk_link = ~clk_link;
  rtcis_port u_dut (.clk_sys, .sys_rst, .ce, .clk_link, .scl_in(scl), .sda_in(sda),
    .sda_out, .sda_oe, .port_select_in, .on_battery, .vdd_low_in, .power_fail_out,
    .hazard_clear, .corrupt_hazard, .core_we, .core_addr, .core_wdata, .core_rdata);
  rtcis_master u_mst (.clk(clk_link), .sda_in(sda), .scl, .sda_drv, .obs_vld, .obs_data);
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // note the expected result, then run the byte on the bus
  task automatic tx(input logic [7:0] b, input logic rd, input logic last, input logic [7:0] e);
    q.push_back(e);
    u_mst.xfer(b, rd, last);
  endtask
  task automatic core_rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk_sys) core_addr <= a;
    repeat (2) @(posedge clk_sys);
    #1 check("core_rdata", core_rdata, e);
  endtask
  // result watcher pairs each byte result with the oldest note
  always @(posedge clk_link)
    if (obs_vld === 1'b1)
    begin
      if (q.size() == 0)
        check("queue", 8'hEE, 8'h00);
      else
        check("byte_result", obs_data, q.pop_front());
    end
  // hang guard, well above the roughly 30k cycles the run needs
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      mismatches++;
      end_sim();
    end
  end
  initial
  begin
    {sys_rst, ce, port_select_in} = 3'b111;
    {on_battery, vdd_low_in, hazard_clear, core_we} = 4'h0;
    core_addr = 5'h00;
    core_wdata = 8'h00;
    for (int i = 0; i < 3; i++) d[i] = 8'($random(seed));
    cw = 8'($random(seed));
    // six link clocks, so the link side reset takes hold through its synchroniser
    repeat (6) @(posedge clk_link);
    @(posedge clk_sys) sys_rst <= 1'b0;
    repeat (8) @(posedge clk_link);
    // write across the last register into register zero
    u_mst.start();
    tx(8'hA2, 1'b0, 1'b0, 8'h01);
    tx(8'h1C, 1'b0, 1'b0, 8'h01);
    for (int i = 0; i < 3; i++) tx(d[i], 1'b0, 1'b0, 8'h01);
    u_mst.stop();
    core_rd(5'h1C, d[0]);
    core_rd(5'h00, d[2]);
    @(posedge clk_sys) {core_we, core_addr, core_wdata} <= {1'b1, 5'h00, cw};
    @(posedge clk_sys) core_we <= 1'b0;
    core_rd(5'h00, cw);
    // set pointer, then read with wrap and final nack
    u_mst.start();
    tx(8'hA2, 1'b0, 1'b0, 8'h01);
    tx(8'h1D, 1'b0, 1'b0, 8'h01);
    u_mst.stop();
    u_mst.start();
    tx(8'hA3, 1'b0, 1'b0, 8'h01);
    tx(8'hFF, 1'b1, 1'b0, d[1]);
    tx(8'hFF, 1'b1, 1'b1, cw);
    tx(8'hFF, 1'b1, 1'b1, 8'hFF);
    u_mst.stop();
    // foreign addresses are ignored
    foreach (d[i])
    begin
      u_mst.start();
      tx(8'hA0 ^ (8'h04 << i), 1'b0, 1'b0, 8'h00);
      u_mst.stop();
    end
    // deselected port stays silent and idle; selecting it again re-arms it
    @(posedge clk_sys) port_select_in <= 1'b0;
    u_mst.start();
    tx(8'hA2, 1'b0, 1'b0, 8'h00);
    @(posedge clk_sys) port_select_in <= 1'b1;
    u_mst.stop();
    // supply warning follows the monitor input
    @(posedge clk_sys) vdd_low_in <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 check("power_fail_out", {7'h00, power_fail_out}, 8'h01);
    @(posedge clk_sys) vdd_low_in <= 1'b0;
    repeat (8) @(posedge clk_sys);
    #1 check("power_fail_out", {7'h00, power_fail_out}, 8'h00);
    // battery switch in mid transfer, then resync by stop and start
    u_mst.start();
    tx(8'hA2, 1'b0, 1'b0, 8'h01);
    @(posedge clk_sys) on_battery <= 1'b1;
    repeat (10) @(posedge clk_sys);
    #1 check("corrupt_hazard", {7'h00, corrupt_hazard}, 8'h01);
    tx(8'h00, 1'b0, 1'b0, 8'h00);
    @(posedge clk_sys) on_battery <= 1'b0;
    repeat (10) @(posedge clk_link);
    u_mst.start();
    tx(8'hA2, 1'b0, 1'b0, 8'h00);
    u_mst.stop();
    u_mst.start();
    tx(8'hA2, 1'b0, 1'b0, 8'h01);
    u_mst.stop();
    repeat (10) @(posedge clk_sys);
    hazard_clear <= 1'b1;
    @(posedge clk_sys) hazard_clear <= 1'b0;
    #1 check("corrupt_hazard", {7'h00, corrupt_hazard}, 8'h00);
    repeat (4) @(posedge clk_link);
    check("queue_left", 8'(q.size()), 8'h00);
    end_sim();
  end
endmodule
